// [core/scpc_pkg.sv]
// scpc_pkg: constants shared by the sensor channel parameter store.
// assumes a 32-bit apb slave, word-aligned registers, byte address = 4 x index.
package scpc_pkg;

    // ==========================================================
    // register indices (printed offsets); byte address is 4 x index
    localparam logic [5:0] SCPC_IDX_BUS_ADDR = 6'h00;
    localparam logic [5:0] SCPC_IDX_CHAN_LIST = 6'h01;
    localparam logic [5:0] SCPC_IDX_LED12 = 6'h02;
    localparam logic [5:0] SCPC_IDX_LED3 = 6'h03;
    localparam logic [5:0] SCPC_IDX_PS_ALIGN = 6'h05;
    localparam logic [5:0] SCPC_IDX_ALS_ALIGN = 6'h06;
    localparam logic [5:0] SCPC_IDX_ACTIVE_ADDR = 6'h10;
    localparam logic [5:0] SCPC_IDX_RESULT_BASE = 6'h20;
    localparam logic [5:0] SCPC_RESULT_WORDS = 6'h06;

    // ==========================================================
    // writable bit masks; reserved bits store and read as zero
    localparam logic [7:0] SCPC_MASK_BUS_ADDR = 8'hff;
    localparam logic [7:0] SCPC_MASK_CHAN_LIST = 8'h77;
    localparam logic [7:0] SCPC_MASK_LED12 = 8'h77;
    localparam logic [7:0] SCPC_MASK_LED3 = 8'h07;
    localparam logic [7:0] SCPC_MASK_PS_ALIGN = 8'h70;
    localparam logic [7:0] SCPC_MASK_ALS_ALIGN = 8'h30;

    // ==========================================================
    // reset values
    localparam logic [7:0] SCPC_RST_BUS_ADDR = 8'h00;
    localparam logic [7:0] SCPC_RST_LED3 = 8'h04;

    // ==========================================================
    // field positions
    localparam int SCPC_BIT_AUX_ON = 6;
    localparam int SCPC_BIT_AMB_IR_ON = 5;
    localparam int SCPC_BIT_AMB_VIS_ON = 4;
    localparam int SCPC_BIT_P3_ON = 2;
    localparam int SCPC_BIT_P2_ON = 1;
    localparam int SCPC_BIT_P1_ON = 0;
    localparam int SCPC_LSB_P2_MASK = 4;
    localparam int SCPC_LSB_P1_MASK = 0;
    localparam int SCPC_LSB_P3_MASK = 0;
    localparam int SCPC_BIT_P3_LOW = 6;
    localparam int SCPC_BIT_P2_LOW = 5;
    localparam int SCPC_BIT_P1_LOW = 4;
    localparam int SCPC_BIT_AMB_IR_LOW = 5;
    localparam int SCPC_BIT_AMB_VIS_LOW = 4;

    // ==========================================================
    // measurement codes from the sequencer, also the result word index
    localparam logic [2:0] SCPC_CH_P1 = 3'h0;
    localparam logic [2:0] SCPC_CH_P2 = 3'h1;
    localparam logic [2:0] SCPC_CH_P3 = 3'h2;
    localparam logic [2:0] SCPC_CH_AMB_VIS = 3'h3;
    localparam logic [2:0] SCPC_CH_AMB_IR = 3'h4;
    localparam logic [2:0] SCPC_CH_AUX = 3'h5;

endpackage

// [core/scpc_mem_if.sv]
// scpc_mem_if: carries the result store's write and read ports.
// assumes one clock shared by both ends.
`timescale 1ns/10ps
interface scpc_mem_if;
    logic wr_en;
    logic [2:0] wr_addr;
    logic [15:0] wr_data;
    logic [2:0] rd_addr;
    logic [15:0] rd_data;

    modport owner (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
    modport store (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface

// [core/scpc_result_mem.sv]
// scpc_result_mem: small store for the reported measurement words.
// assumes synchronous write, read data registered one cycle after address.
`timescale 1ns/10ps
module scpc_result_mem #(
    parameter int DEPTH = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // ports
    scpc_mem_if.store mem
);
    logic [15:0] words_r [DEPTH];
    logic [15:0] rd_r;

    // ==========================================================
    // storage: words clear at reset so unmeasured channels read zero
    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < DEPTH; i++) begin
                words_r[i] <= 16'h0000;
            end
            rd_r <= 16'h0000;
        end else begin
            if (mem.wr_en) begin
                words_r[mem.wr_addr] <= mem.wr_data;
            end
            rd_r <= words_r[mem.rd_addr];
        end
    end

    assign mem.rd_data = rd_r;
endmodule

// [core/scpc_param_store.sv]
// scpc_param_store: parameter store and result formatter for the sensor channels.
// assumes an apb master on clk, and a measurement sequencer that presents
// its channel code while busy and a 17-bit conversion with a valid pulse.
`timescale 1ns/10ps
// Operation
// - stored address becomes active only when the apply-address command arrives; resets zero.
// - channel list bit 6 enables auxiliary measurement and its result pair.
// - channel list bit 5 enables ambient infrared measurement and its result pair.
// - channel list bit 4 enables ambient visible measurement and its result pair.
// - channel list bits 0..2 enable the three proximity measurements and results.
// - second proximity drives emitters from mask bits 6..4; zero drives none.
// - first proximity drives emitters from mask bits 2..0; zero drives none.
// - third proximity mask bits 2..0, reset selects emitter three only.
// - encoding bit 6 picks low or high 16 bits for third proximity.
// - encoding bit 5 picks low or high 16 bits for second proximity.
// - encoding bit 4 picks low or high 16 bits for first proximity.
// - ambient encoding bit 5 picks low or high 16 bits, infrared channel.
// - ambient encoding bit 4 picks low or high 16 bits, visible channel.
module scpc_param_store #(
    parameter int ADDR_W = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // serial bus address control
    input wire logic apply_new_address_cmd,
    output logic [7:0] active_bus_addr,
    // measurement sequencer
    input wire logic meas_busy,
    input wire logic [2:0] meas_chan,
    input wire logic meas_valid,
    input wire logic [16:0] meas_data,
    // configuration seen by the sequencer
    output logic prox_one_on,
    output logic prox_two_on,
    output logic prox_three_on,
    output logic ambient_visible_on,
    output logic ambient_infrared_on,
    output logic auxiliary_on,
    // emitter drive
    output logic [2:0] emitter_drive
);
    import scpc_pkg::*;

    typedef struct packed {
        logic [7:0] bus_addr;
        logic [7:0] active_addr;
        logic [7:0] chan_list;
        logic [7:0] led12;
        logic [7:0] led3;
        logic [7:0] ps_align;
        logic [7:0] als_align;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic [2:0] led_drive;
        logic wr_en;
        logic [2:0] wr_addr;
        logic [15:0] wr_data;
    } scpc_state_s;

    scpc_state_s st_r;
    scpc_state_s st_nxt;
    scpc_mem_if mem ();

    // ==========================================================
    // helpers
    function automatic logic [ADDR_W-1:0] byte_addr(input logic [5:0] idx);
        byte_addr = ADDR_W'({idx, 2'b00});
    endfunction

    // 17-bit conversion cut to the reported 16-bit word
    function automatic logic [15:0] align17(input logic [16:0] d, input logic low_sel);
        align17 = low_sel ? d[15:0] : d[16:1];
    endfunction

    function automatic logic in_results(input logic [ADDR_W-1:0] a);
        in_results = (a >= byte_addr(SCPC_IDX_RESULT_BASE)) &&
                     (a < byte_addr(SCPC_IDX_RESULT_BASE + SCPC_RESULT_WORDS));
    endfunction

    // ==========================================================
    // result store
    scpc_result_mem #(
        .DEPTH(8)
    ) u_store (
        .clk(clk),
        .rst(rst),
        .mem(mem.store)
    );

    // read address follows the bus so data is ready in the first access cycle
    assign mem.wr_en = st_r.wr_en;
    assign mem.wr_addr = st_r.wr_addr;
    assign mem.wr_data = st_r.wr_data;
    assign mem.rd_addr = paddr[4:2];

    // ==========================================================
    // next-state logic
    always_comb begin
        logic acc_first;
        logic acc_done;
        logic [7:0] wb;
        acc_first = psel && penable && !st_r.pready;
        acc_done = psel && penable && st_r.pready;
        wb = pwdata[7:0];
        st_nxt = st_r;
        st_nxt.pready = 1'b0;
        st_nxt.pslverr = 1'b0;
        st_nxt.wr_en = 1'b0;
        st_nxt.led_drive = 3'b000;

        // first access cycle: decode and register the answer (one wait state)
        if (acc_first) begin
            st_nxt.pready = 1'b1;
            st_nxt.prdata = 32'h0000_0000;
            if (paddr == byte_addr(SCPC_IDX_BUS_ADDR)) begin
                st_nxt.prdata = {24'h00_0000, st_r.bus_addr};
            end else if (paddr == byte_addr(SCPC_IDX_CHAN_LIST)) begin
                st_nxt.prdata = {24'h00_0000, st_r.chan_list};
            end else if (paddr == byte_addr(SCPC_IDX_LED12)) begin
                st_nxt.prdata = {24'h00_0000, st_r.led12};
            end else if (paddr == byte_addr(SCPC_IDX_LED3)) begin
                st_nxt.prdata = {24'h00_0000, st_r.led3};
            end else if (paddr == byte_addr(SCPC_IDX_PS_ALIGN)) begin
                st_nxt.prdata = {24'h00_0000, st_r.ps_align};
            end else if (paddr == byte_addr(SCPC_IDX_ALS_ALIGN)) begin
                st_nxt.prdata = {24'h00_0000, st_r.als_align};
            end else if (paddr == byte_addr(SCPC_IDX_ACTIVE_ADDR)) begin
                st_nxt.prdata = {24'h00_0000, st_r.active_addr};
                st_nxt.pslverr = pwrite; // read-only
            end else if (in_results(paddr)) begin
                st_nxt.prdata = {16'h0000, mem.rd_data};
                st_nxt.pslverr = pwrite; // read-only
            end else begin
                st_nxt.pslverr = 1'b1; // unmapped
            end
            if (pwrite) begin
                st_nxt.prdata = 32'h0000_0000;
            end
        end

        // writes land at the completing edge; reserved bits are dropped
        if (acc_done && pwrite && pstrb[0]) begin
            if (paddr == byte_addr(SCPC_IDX_BUS_ADDR)) begin
                st_nxt.bus_addr = wb & SCPC_MASK_BUS_ADDR;
            end else if (paddr == byte_addr(SCPC_IDX_CHAN_LIST)) begin
                st_nxt.chan_list = wb & SCPC_MASK_CHAN_LIST;
            end else if (paddr == byte_addr(SCPC_IDX_LED12)) begin
                st_nxt.led12 = wb & SCPC_MASK_LED12;
            end else if (paddr == byte_addr(SCPC_IDX_LED3)) begin
                st_nxt.led3 = wb & SCPC_MASK_LED3;
            end else if (paddr == byte_addr(SCPC_IDX_PS_ALIGN)) begin
                st_nxt.ps_align = wb & SCPC_MASK_PS_ALIGN;
            end else if (paddr == byte_addr(SCPC_IDX_ALS_ALIGN)) begin
                st_nxt.als_align = wb & SCPC_MASK_ALS_ALIGN;
            end
        end

        // the old address stays live until the apply command
        if (apply_new_address_cmd) begin
            st_nxt.active_addr = st_r.bus_addr;
        end

        // emitter drive while a proximity measurement runs
        if (meas_busy) begin
            case (meas_chan)
                SCPC_CH_P1: st_nxt.led_drive = st_r.led12[SCPC_LSB_P1_MASK +: 3];
                SCPC_CH_P2: st_nxt.led_drive = st_r.led12[SCPC_LSB_P2_MASK +: 3];
                SCPC_CH_P3: st_nxt.led_drive = st_r.led3[SCPC_LSB_P3_MASK +: 3];
                default: st_nxt.led_drive = 3'b000;
            endcase
        end

        // results of enabled channels only reach the store
        if (meas_valid) begin
            st_nxt.wr_addr = meas_chan;
            case (meas_chan)
                SCPC_CH_P1: begin
                    st_nxt.wr_en = st_r.chan_list[SCPC_BIT_P1_ON];
                    st_nxt.wr_data = align17(meas_data, st_r.ps_align[SCPC_BIT_P1_LOW]);
                end
                SCPC_CH_P2: begin
                    st_nxt.wr_en = st_r.chan_list[SCPC_BIT_P2_ON];
                    st_nxt.wr_data = align17(meas_data, st_r.ps_align[SCPC_BIT_P2_LOW]);
                end
                SCPC_CH_P3: begin
                    st_nxt.wr_en = st_r.chan_list[SCPC_BIT_P3_ON];
                    st_nxt.wr_data = align17(meas_data, st_r.ps_align[SCPC_BIT_P3_LOW]);
                end
                SCPC_CH_AMB_VIS: begin
                    st_nxt.wr_en = st_r.chan_list[SCPC_BIT_AMB_VIS_ON];
                    st_nxt.wr_data = align17(meas_data,
                        st_r.als_align[SCPC_BIT_AMB_VIS_LOW]);
                end
                SCPC_CH_AMB_IR: begin
                    st_nxt.wr_en = st_r.chan_list[SCPC_BIT_AMB_IR_ON];
                    st_nxt.wr_data = align17(meas_data,
                        st_r.als_align[SCPC_BIT_AMB_IR_LOW]);
                end
                SCPC_CH_AUX: begin
                    st_nxt.wr_en = st_r.chan_list[SCPC_BIT_AUX_ON];
                    st_nxt.wr_data = align17(meas_data, 1'b0);
                end
                default: st_nxt.wr_en = 1'b0;
            endcase
        end
    end

    // ==========================================================
    // state register; unlisted parameters reset to zero
    always_ff @(posedge clk) begin
        if (rst) begin
            st_r <= '0;
            st_r.bus_addr <= SCPC_RST_BUS_ADDR;
            st_r.led3 <= SCPC_RST_LED3;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ==========================================================
    // outputs, all straight from the state register
    assign prdata = st_r.prdata;
    assign pready = st_r.pready;
    assign pslverr = st_r.pslverr;
    assign active_bus_addr = st_r.active_addr;
    assign prox_one_on = st_r.chan_list[SCPC_BIT_P1_ON];
    assign prox_two_on = st_r.chan_list[SCPC_BIT_P2_ON];
    assign prox_three_on = st_r.chan_list[SCPC_BIT_P3_ON];
    assign ambient_visible_on = st_r.chan_list[SCPC_BIT_AMB_VIS_ON];
    assign ambient_infrared_on = st_r.chan_list[SCPC_BIT_AMB_IR_ON];
    assign auxiliary_on = st_r.chan_list[SCPC_BIT_AUX_ON];
    assign emitter_drive = st_r.led_drive;

    // ==========================================================
    // checks
    a_addr_apply: assert property (@(posedge clk) disable iff (rst)
        apply_new_address_cmd |=> active_bus_addr == $past(st_r.bus_addr))
        else $error("active address did not take the stored value");

    a_addr_hold: assert property (@(posedge clk) disable iff (rst)
        !apply_new_address_cmd |=> $stable(active_bus_addr))
        else $error("active address changed without apply command");

    a_led_prox_two: assert property (@(posedge clk) disable iff (rst)
        (meas_busy && meas_chan == SCPC_CH_P2) |=> emitter_drive == $past(st_r.led12[6:4]))
        else $error("second proximity emitters wrong");

    a_led_prox_one: assert property (@(posedge clk) disable iff (rst)
        (meas_busy && meas_chan == SCPC_CH_P1) |=> emitter_drive == $past(st_r.led12[2:0]))
        else $error("first proximity emitters wrong");

    a_led_prox_three: assert property (@(posedge clk) disable iff (rst)
        (meas_busy && meas_chan == SCPC_CH_P3) |=> emitter_drive == $past(st_r.led3[2:0]))
        else $error("third proximity emitters wrong");

    a_led_reset_three: assert property (@(posedge clk)
        rst |=> st_r.led3 == 8'h04 && active_bus_addr == 8'h00)
        else $error("reset values wrong");

    a_store_gate: assert property (@(posedge clk) disable iff (rst)
        (meas_valid && meas_chan == SCPC_CH_P1 && !prox_one_on) |=> !mem.wr_en)
        else $error("disabled channel stored a result");

    a_align_prox_one: assert property (@(posedge clk) disable iff (rst)
        (meas_valid && meas_chan == SCPC_CH_P1 && prox_one_on && st_r.ps_align[4])
        |=> mem.wr_en && mem.wr_data == $past(meas_data[15:0]))
        else $error("first proximity low word not reported");

    a_align_amb_ir: assert property (@(posedge clk) disable iff (rst)
        (meas_valid && meas_chan == SCPC_CH_AMB_IR && ambient_infrared_on && !st_r.als_align[5])
        |=> mem.wr_en && mem.wr_data == $past(meas_data[16:1]))
        else $error("ambient infrared high word not reported");

    a_read_upper_zero: assert property (@(posedge clk) disable iff (rst)
        pready |-> prdata[31:16] == 16'h0000 && !$past(pready))
        else $error("read upper bits or ready pulse wrong");

    a_ready_one_wait: assert property (@(posedge clk) disable iff (rst)
        (psel && penable && !pready) |=> pready)
        else $error("apb answer not after one wait state");

    a_led_idle: assert property (@(posedge clk) disable iff (rst)
        !meas_busy |=> emitter_drive == 3'b000)
        else $error("emitters driven while idle");

    a_led_not_prox: assert property (@(posedge clk) disable iff (rst)
        (meas_busy && meas_chan > SCPC_CH_P3) |=> emitter_drive == 3'b000)
        else $error("emitters driven for a non-proximity channel");

    a_gate_prox_two: assert property (@(posedge clk) disable iff (rst)
        (meas_valid && meas_chan == SCPC_CH_P2 && !prox_two_on) |=> !mem.wr_en)
        else $error("disabled second proximity stored");

    a_gate_prox_three: assert property (@(posedge clk) disable iff (rst)
        (meas_valid && meas_chan == SCPC_CH_P3 && !prox_three_on) |=> !mem.wr_en)
        else $error("disabled third proximity stored");

    a_gate_amb_vis: assert property (@(posedge clk) disable iff (rst)
        (meas_valid && meas_chan == SCPC_CH_AMB_VIS && !ambient_visible_on) |=> !mem.wr_en)
        else $error("disabled ambient visible stored");

    a_gate_amb_ir: assert property (@(posedge clk) disable iff (rst)
        (meas_valid && meas_chan == SCPC_CH_AMB_IR && !ambient_infrared_on) |=> !mem.wr_en)
        else $error("disabled ambient infrared stored");

    a_gate_aux: assert property (@(posedge clk) disable iff (rst)
        (meas_valid && meas_chan == SCPC_CH_AUX && !auxiliary_on) |=> !mem.wr_en)
        else $error("disabled auxiliary stored");

    a_store_aux: assert property (@(posedge clk) disable iff (rst)
        (meas_valid && meas_chan == SCPC_CH_AUX && auxiliary_on)
        |=> mem.wr_en && mem.wr_addr == SCPC_CH_AUX && mem.wr_data == $past(meas_data[16:1]))
        else $error("auxiliary result not stored");

    a_align_prox_two: assert property (@(posedge clk) disable iff (rst)
        (meas_valid && meas_chan == SCPC_CH_P2 && prox_two_on && st_r.ps_align[5])
        |=> mem.wr_en && mem.wr_data == $past(meas_data[15:0]))
        else $error("second proximity low word not reported");

    a_align_prox_three: assert property (@(posedge clk) disable iff (rst)
        (meas_valid && meas_chan == SCPC_CH_P3 && prox_three_on && !st_r.ps_align[6])
        |=> mem.wr_en && mem.wr_data == $past(meas_data[16:1]))
        else $error("third proximity high word not reported");

    a_align_one_high: assert property (@(posedge clk) disable iff (rst)
        (meas_valid && meas_chan == SCPC_CH_P1 && prox_one_on && !st_r.ps_align[4])
        |=> mem.wr_en && mem.wr_data == $past(meas_data[16:1]))
        else $error("first proximity high word not reported");

    a_align_amb_vis: assert property (@(posedge clk) disable iff (rst)
        (meas_valid && meas_chan == SCPC_CH_AMB_VIS && ambient_visible_on && st_r.als_align[4])
        |=> mem.wr_en && mem.wr_data == $past(meas_data[15:0]))
        else $error("ambient visible low word not reported");

    a_align_ir_low: assert property (@(posedge clk) disable iff (rst)
        (meas_valid && meas_chan == SCPC_CH_AMB_IR && ambient_infrared_on && st_r.als_align[5])
        |=> mem.wr_en && mem.wr_data == $past(meas_data[15:0]))
        else $error("ambient infrared low word not reported");

    a_reserved_zero: assert property (@(posedge clk) disable iff (rst)
        !st_r.chan_list[7] && !st_r.chan_list[3] && st_r.ps_align[3:0] == 4'h0
        && st_r.als_align[3:0] == 4'h0)
        else $error("reserved parameter bits not zero");
endmodule

// [testbench/scpc_seq_model.sv]
// scpc_seq_model: measurement sequencer beside the parameter store.
// assumes the store samples busy and valid on the rising edge of clk.
`timescale 1ns/10ps
module scpc_seq_model (
    // clock
    input wire logic clk,
    // sequencer drive
    output logic meas_busy,
    output logic [2:0] meas_chan,
    output logic meas_valid,
    output logic [16:0] meas_data,
    // emitter feedback
    input wire logic [2:0] emitter_drive
);
    // ==========================================================
    // idle levels; the channel code shows an unused value until the first measurement
    initial begin
        meas_busy = 1'b0;
        meas_chan = 3'h7;
        meas_valid = 1'b0;
        meas_data = 17'h0;
    end

    // one measurement: busy, emitter sampled, then a single valid pulse
    task automatic measure(input logic [2:0] ch, input logic [16:0] d, output logic [2:0] em);
        meas_busy <= 1'b1;
        meas_chan <= ch;
        @(posedge clk);
        @(posedge clk);
        em = emitter_drive;
        meas_valid <= 1'b1;
        meas_data <= d;
        @(posedge clk);
        meas_valid <= 1'b0;
        meas_busy <= 1'b0;
        meas_data <= ~d; // released data must not look like a fresh sample
        @(posedge clk);
    endtask
endmodule

// [testbench/sensor_channel_param_config_tb_top.sv]
// sensor_channel_param_config_tb_top: apb tests of the parameter store.
// assumes one 100 mhz clock and a synchronous active-high reset.
`timescale 1ns/10ps
module sensor_channel_param_config_tb_top;
    import scpc_pkg::*;
    logic clk, rst, psel, penable, pwrite, pready, pslverr, apply_new_address_cmd;
    logic [7:0] paddr, active_bus_addr, ra;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb;
    logic meas_busy, meas_valid, er;
    logic [2:0] meas_chan, emitter_drive, em, c;
    logic [16:0] meas_data, d;
    logic [5:0] chans, lo;
    logic [15:0] last;
    int mismatches = 0;
    int check_count = 0;
    int cyc = 0;
    logic [7:0] addrs [6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h14, 8'h18};
    logic [7:0] wvals [6] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'hf0, 8'hf0};
    logic [7:0] rvals [6] = '{8'hff, 8'h77, 8'h77, 8'h07, 8'h70, 8'h30};
    logic [2:0] emexp [6] = '{3'h3, 3'h5, 3'h6, 3'h0, 3'h0, 3'h0};

    scpc_param_store #(.ADDR_W(8)) DUT (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .apply_new_address_cmd(apply_new_address_cmd),
        .active_bus_addr(active_bus_addr), .meas_busy(meas_busy), .meas_chan(meas_chan),
        .meas_valid(meas_valid), .meas_data(meas_data), .prox_one_on(chans[0]),
        .prox_two_on(chans[1]), .prox_three_on(chans[2]), .ambient_visible_on(chans[3]),
        .ambient_infrared_on(chans[4]), .auxiliary_on(chans[5]), .emitter_drive(emitter_drive));

    scpc_seq_model seq (.clk(clk), .meas_busy(meas_busy), .meas_chan(meas_chan),
        .meas_valid(meas_valid), .meas_data(meas_data), .emitter_drive(emitter_drive));

    // ==========================================================
    // clock and hang guard; the run needs well under a thousand cycles
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            mismatches++;
            conclude();
        end
    end

    // ==========================================================
    // comparison and closing report
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // ==========================================================
    // apb transfer; request held until pready is seen high at an edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rdat, output logic err);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        // only the bench's cycle ceiling ends a wait that never answers
        while (pready !== 1'b1) begin
            @(posedge clk);
        end
        rdat = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        apb(1'b1, a, {24'h0, v}, rd, er);
        chk({31'h0, er}, 32'h0);
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input logic ee);
        apb(1'b0, a, 32'h0, rd, er);
        chk(rd, exp);
        chk({31'h0, er}, {31'h0, ee});
    endtask

    // ==========================================================
    // main sequence
    initial begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h0;
        pwdata = 32'h0;
        pstrb = 4'hf;
        apply_new_address_cmd = 1'b0;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rdchk(8'h00, 32'h0, 1'b0);
        rdchk(8'h0c, 32'h4, 1'b0);
        chk({24'h0, active_bus_addr}, 32'h0);
        // every writable bit set; reserved bits must read back zero
        for (int i = 0; i < 6; i++) begin
            wr(addrs[i], wvals[i]);
            rdchk(addrs[i], {24'h0, rvals[i]}, 1'b0);
        end
        chk({26'h0, chans}, 32'h3f);
        wr(8'h04, 8'h52);
        chk({26'h0, chans}, 32'h2a);
        wr(8'h04, 8'h25);
        chk({26'h0, chans}, 32'h15);
        rdchk(8'h10, 32'h0, 1'b1);
        // a write without its low byte strobe must leave the mask alone
        pstrb <= 4'he;
        wr(8'h0c, 8'h01);
        pstrb <= 4'hf;
        rdchk(8'h0c, 32'h7, 1'b0);
        // new address waits for the apply command
        wr(8'h00, 8'h5a);
        chk({24'h0, active_bus_addr}, 32'h0);
        apply_new_address_cmd <= 1'b1;
        @(posedge clk);
        apply_new_address_cmd <= 1'b0;
        @(posedge clk);
        chk({24'h0, active_bus_addr}, 32'h5a);
        wr(8'h00, 8'h33);
        chk({24'h0, active_bus_addr}, 32'h5a);
        // the live address is read-only from the bus
        apb(1'b1, 8'h40, 32'h77, rd, er);
        chk({31'h0, er}, 32'h1);
        chk({24'h0, active_bus_addr}, 32'h5a);
        // emitter masks and word alignment, two complementary passes
        wr(8'h08, 8'h53);
        wr(8'h0c, 8'h06);
        wr(8'h04, 8'h77);
        for (int p = 0; p < 2; p++) begin
            wr(8'h14, p == 0 ? 8'h50 : 8'h20);
            wr(8'h18, p == 0 ? 8'h20 : 8'h10);
            lo = (p == 0) ? 6'b010101 : 6'b001010;
            for (int ch = 0; ch < 6; ch++) begin
                c = ch[2:0];
                ra = {3'h4, c, 2'b00};
                d = 17'h16b4c ^ {10'h0, c, p[0], c};
                seq.measure(c, d, em);
                chk({29'h0, em}, {29'h0, emexp[ch]});
                last = lo[ch] ? d[15:0] : d[16:1];
                rdchk(ra, {16'h0, last}, 1'b0);
            end
        end
        // disabled channels keep the words of the second pass
        wr(8'h04, 8'h00);
        chk({26'h0, chans}, 32'h0);
        for (int ch = 0; ch < 6; ch++) begin
            c = ch[2:0];
            ra = {3'h4, c, 2'b00};
            d = 17'h16b4c ^ {10'h0, c, 1'b1, c};
            seq.measure(c, 17'h0f0f0, em);
            last = lo[ch] ? d[15:0] : d[16:1];
            rdchk(ra, {16'h0, last}, 1'b0);
        end
        conclude();
    end
endmodule
